// ---- fsp_cfg.svh ----
// address map, lock encodings and reset values for the flash protection map
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH
`define FSP_APP_LAST 18'h1EFFF
`define FSP_TBL_FIRST 18'h1F000
`define FSP_TBL_LAST 18'h1FFFF
`define FSP_BOOT_FIRST 18'h20000
`define FSP_BOOT_LAST 18'h20FFF
`define FSP_EE_MAP_BASE 16'h1000
`define FSP_EE_MAP_LAST 16'h1FFF
`define FSP_IO_SHORT_LAST 8'h3F
`define FSP_IO_BIT_LAST 8'h1F
`define FSP_GPR_LAST 8'h0F
`define FSP_LOCK_ERASED 2'h3
`define FSP_FUSE_ERASED 8'hFF
`define FSP_SIG_DEV_ID 24'h000000
`define FSP_ADDR_LOCK 12'h000
`define FSP_ADDR_FUSE 12'h004
`define FSP_ADDR_CTRL 12'h008
`define FSP_ADDR_STAT 12'h00C
`define FSP_ADDR_DEVID 12'h010
`define FSP_ADDR_SERIAL 12'h014
`define FSP_ADDR_CAL 12'h018
`define FSP_ADDR_GPR 12'h040
`define FSP_GPR_SEL 6'h01
`define FSP_USER_SEL 2'h2
`define FSP_ERASE_STEPS 4'h8
`endif

// ---- fsp_data_decode.sv ----
// data-space decode for io, mapped eeprom and sram
`timescale 1ns/1ps
`include "fsp_cfg.svh"
module fsp_data_decode
(
  input wire logic [15:0] daddr,
  input wire logic ee_map_en,
  output fsp_pkg::fsp_dspace_t space,
  output fsp_pkg::fsp_dinfo_t info
);
  always_comb
  begin
    info = '0;
    info.is_io = daddr < `FSP_EE_MAP_BASE;
    info.is_ee_mapped = ee_map_en && daddr >= `FSP_EE_MAP_BASE &&
                        daddr <= `FSP_EE_MAP_LAST;
    info.short_io_ok = daddr <= {8'h00, `FSP_IO_SHORT_LAST};
    info.bit_io_ok = daddr <= {8'h00, `FSP_IO_BIT_LAST};
    info.is_gpr = daddr <= {8'h00, `FSP_GPR_LAST};
    if (info.is_io)
      space = fsp_pkg::FSP_DS_IO;
    else if (info.is_ee_mapped)
      space = fsp_pkg::FSP_DS_EEPROM;
    else
      space = fsp_pkg::FSP_DS_SRAM;
  end
endmodule : fsp_data_decode

// ---- fsp_flash_decode.sv ----
// flash word address to region and per-region access check
`timescale 1ns/1ps
`include "fsp_cfg.svh"
module fsp_flash_decode
(
  input wire fsp_pkg::fsp_freq_t req,
  input wire fsp_pkg::fsp_locks_t locks,
  output fsp_pkg::fsp_region_t region,
  output logic allow
);
  function automatic fsp_pkg::fsp_region_t fsp_region_of(input logic [17:0] a);
    if (a <= `FSP_APP_LAST)
      fsp_region_of = fsp_pkg::FSP_REG_APP;
    else if (a <= `FSP_TBL_LAST)
      fsp_region_of = fsp_pkg::FSP_REG_TBL;
    else if (a <= `FSP_BOOT_LAST)
      fsp_region_of = fsp_pkg::FSP_REG_BOOT;
    else
      fsp_region_of = fsp_pkg::FSP_REG_NONE;
  endfunction : fsp_region_of
  logic [1:0] lk;
  logic spm_ok;
  always_comb
  begin
    region = fsp_region_of(req.waddr);
    case (region)
      fsp_pkg::FSP_REG_APP: lk = locks.app;
      fsp_pkg::FSP_REG_TBL: lk = locks.tbl;
      fsp_pkg::FSP_REG_BOOT: lk = locks.boot;
      default: lk = 2'h0;
    endcase
    // store-program only from boot code, any target
    spm_ok = req.from_prog || !req.store_program_word_instr || (fsp_region_of(req.fetch_pc) == fsp_pkg::FSP_REG_BOOT);
    // bit0 low blocks write, bit1 low blocks read
    allow = req.valid && region != fsp_pkg::FSP_REG_NONE && spm_ok &&
            (req.write ? lk[0] : lk[1]);
  end
endmodule : fsp_flash_decode

// ---- fsp_flash_section_protection_map.sv ----
// top: flash region protection, lock and fuse store, signature rows, data decode, apb slave
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "fsp_cfg.svh"
module fsp_flash_section_protection_map #(
  parameter logic [23:0] DEV_ID = `FSP_SIG_DEV_ID, // arbitrary value
  parameter logic [31:0] SERIAL = 32'h00000000, // arbitrary value
  parameter logic [7:0] CAL_AUTO = 8'h00,
  parameter int USER_ROW_WORDS = 256
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash access request from cpu or programmer
  input wire logic fl_valid,
  input wire logic fl_write,
  input wire logic fl_from_prog,
  input wire logic fl_spm,
  input wire logic [17:0] fl_waddr,
  input wire logic [17:0] fl_fetch_pc,
  input wire logic [15:0] fl_wdata,
  input wire logic fl_instr_long,
  // programmer-only commands
  input wire logic prog_fuse_wr,
  input wire logic [7:0] prog_fuse_data,
  input wire logic prog_lock_wr,
  input wire logic [5:0] prog_lock_data,
  input wire logic prog_chip_erase,
  input wire logic prog_user_erase,
  input wire logic prog_user_wr,
  input wire logic [7:0] prog_user_idx,
  input wire logic [15:0] prog_user_data,
  // data-space decode
  input wire logic [15:0] daddr,
  output logic fl_grant,
  output logic fl_mem_we,
  output logic [15:0] fl_mem_wdata,
  output logic fl_words,
  output logic fl_mem_erase,
  output logic erase_busy,
  output logic [7:0] cal_out,
  output logic [1:0] dspace,
  output logic [4:0] dinfo
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    fsp_pkg::fsp_locks_t locks;
    logic [7:0] fuse;
    logic ee_map;
    logic [3:0] erase_cnt;
    logic erasing;
    logic grant;
    logic mem_we;
    logic [15:0] mem_wdata;
    logic words;
    logic mem_erase;
    logic refused;
    logic [7:0] cal;
    logic cal_loaded;
    logic [31:0] rdata;
    logic ready;
    logic err;
    fsp_pkg::fsp_dspace_t ds;
    fsp_pkg::fsp_dinfo_t di;
    logic [127:0] gpr;
  } fsp_state_t;
  fsp_state_t s_q;
  fsp_state_t s_d;
  logic [15:0] user_row [USER_ROW_WORDS];
  fsp_pkg::fsp_freq_t req;
  fsp_pkg::fsp_region_t region;
  logic allow;
  fsp_pkg::fsp_dspace_t ds;
  fsp_pkg::fsp_dinfo_t di;
  logic apb_acc;
  logic [7:0] ui;
  assign req = '{valid: fl_valid && !s_q.erasing, write: fl_write, from_prog: fl_from_prog,
                 store_program_word_instr: fl_spm, waddr: fl_waddr, fetch_pc: fl_fetch_pc};
  // ready high blocks a second take while psel and penable still stand
  assign apb_acc = psel && penable && !s_q.ready;
  assign ui = paddr[9:2];
  fsp_flash_decode u_fdec (
    .req(req),
    .locks(s_q.locks),
    .region(region),
    .allow(allow)
  );
  fsp_data_decode u_ddec (
    .daddr(daddr),
    .ee_map_en(s_q.ee_map),
    .space(ds),
    .info(di)
  );
  // ************************************************************
  // user signature row storage
  // ************************************************************
  // kept out of the state struct: chip erase never touches it
  always_ff @(posedge pclk)
  begin
    if (prog_user_erase)
    begin
      for (int i = 0; i < USER_ROW_WORDS; i++)
        user_row[i] <= 16'hFFFF;
    end
    else if (prog_user_wr)
      user_row[prog_user_idx] <= prog_user_data;
    else if (apb_acc && pwrite && paddr[11:10] == `FSP_USER_SEL)
      user_row[ui] <= pwdata[15:0];
  end
  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.grant = 1'b0;
    s_d.mem_we = 1'b0;
    s_d.mem_erase = 1'b0;
    s_d.ready = 1'b0;
    s_d.err = 1'b0;
    s_d.ds = ds;
    s_d.di = di;
    // factory calibration copied once out of reset
    if (!s_q.cal_loaded)
    begin
      s_d.cal = CAL_AUTO;
      s_d.cal_loaded = 1'b1;
    end
    // flash accesses from software or programmer
    if (req.valid)
    begin
      s_d.grant = allow;
      s_d.mem_we = allow && fl_write;
      s_d.mem_wdata = fl_wdata;
      s_d.words = fl_instr_long;
      s_d.refused = !allow;
    end
    // locks: and-in only, so a cleared bit returns to one only at reset or at the end of a chip erase
    if (prog_lock_wr && !s_q.erasing)
      s_d.locks = s_q.locks & prog_lock_data;
    if (prog_fuse_wr && !s_q.erasing)
      s_d.fuse = prog_fuse_data;
    // chip erase: flash first, locks only at the end
    // erase steps and busy flag line up cycle for cycle
    if (prog_chip_erase && !s_q.erasing)
    begin
      s_d.erasing = 1'b1;
      s_d.mem_erase = 1'b1;
      s_d.erase_cnt = `FSP_ERASE_STEPS;
    end
    else if (s_q.erasing)
    begin
      s_d.erase_cnt = s_q.erase_cnt - 4'h1;
      // locks go once the last erase step is over, never alongside it
      if (s_q.erase_cnt == 4'h1)
      begin
        s_d.erasing = 1'b0;
        s_d.locks = '{app: `FSP_LOCK_ERASED, tbl: `FSP_LOCK_ERASED,
                      boot: `FSP_LOCK_ERASED};
      end
      else
        s_d.mem_erase = 1'b1;
    end
    // apb slave, one wait state
    if (apb_acc)
    begin
      s_d.ready = 1'b1;
      s_d.rdata = 32'h00000000;
      if (paddr[11:10] == `FSP_USER_SEL)
      begin
        if (!pwrite)
          s_d.rdata = {16'h0000, user_row[ui]};
      end
      else
      begin
        case (paddr)
          `FSP_ADDR_LOCK:
          begin
            if (pwrite && !s_q.erasing)
              s_d.locks = s_d.locks & pwdata[5:0];
            s_d.rdata = {26'h0, s_q.locks};
          end
          `FSP_ADDR_FUSE:
          begin
            s_d.err = pwrite;
            s_d.rdata = {24'h0, s_q.fuse};
          end
          `FSP_ADDR_CTRL:
          begin
            if (pwrite)
              s_d.ee_map = pwdata[0];
            s_d.rdata = {31'h0, s_q.ee_map};
          end
          `FSP_ADDR_STAT:
          begin
            s_d.err = pwrite;
            s_d.rdata = {30'h0, s_q.refused, s_q.erasing};
          end
          `FSP_ADDR_DEVID:
          begin
            s_d.err = pwrite;
            s_d.rdata = {8'h00, DEV_ID};
          end
          `FSP_ADDR_SERIAL:
          begin
            s_d.err = pwrite;
            s_d.rdata = SERIAL;
          end
          `FSP_ADDR_CAL:
          begin
            s_d.err = pwrite;
            s_d.rdata = {24'h0, s_q.cal};
          end
          default:
          begin
            // general purpose io bytes, 16 of them
            if (paddr[11:6] == `FSP_GPR_SEL)
            begin
              if (pwrite)
                s_d.gpr[paddr[5:2] * 8 +: 8] = pwdata[7:0];
              s_d.rdata = {24'h0, s_q.gpr[paddr[5:2] * 8 +: 8]};
            end
            else
              s_d.err = 1'b1;
          end
        endcase
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.locks <= '{app: `FSP_LOCK_ERASED, tbl: `FSP_LOCK_ERASED, boot: `FSP_LOCK_ERASED};
      s_q.fuse <= `FSP_FUSE_ERASED;
    end
    else
      s_q <= s_d;
  end
  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign fl_grant = s_q.grant;
  assign fl_mem_we = s_q.mem_we;
  assign fl_mem_wdata = s_q.mem_wdata;
  assign fl_words = s_q.words;
  assign fl_mem_erase = s_q.mem_erase;
  assign erase_busy = s_q.erasing;
  assign cal_out = s_q.cal;
  assign dspace = s_q.ds;
  assign dinfo = s_q.di;
  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_spm_app_blocked: assert property ((fl_valid && !s_q.erasing && fl_spm && !fl_from_prog &&
    fl_fetch_pc <= `FSP_APP_LAST) |=> !fl_mem_we && !fl_grant)
    else $error("store-program from outside boot granted");
  a_spm_boot_any: assert property ((fl_valid && !s_q.erasing && fl_spm && fl_write &&
    fl_fetch_pc >= `FSP_BOOT_FIRST && fl_fetch_pc <= `FSP_BOOT_LAST &&
    fl_waddr >= `FSP_BOOT_FIRST && fl_waddr <= `FSP_BOOT_LAST && s_q.locks.boot[0])
    |=> fl_mem_we)
    else $error("boot store-program to boot refused");
  a_lock_no_relax: assert property (!prog_chip_erase && !s_q.erasing |=>
    (s_q.locks & ~$past(s_q.locks)) == 6'h0)
    else $error("lock bit relaxed");
  a_read_lock_app: assert property ((fl_valid && !s_q.erasing && !fl_write &&
    fl_waddr <= `FSP_APP_LAST && !s_q.locks.app[1]) |=> !fl_grant)
    else $error("locked read granted");
  sequence s_erase_run;
    (erase_busy && fl_mem_erase) ##1 (erase_busy && fl_mem_erase && $stable(s_q.locks)) [*7];
  endsequence
  sequence s_erase_done;
    !erase_busy && !fl_mem_erase && s_q.locks == 6'h3F;
  endsequence
  a_erase_locks_last: assert property ($rose(s_q.erasing) |-> s_erase_run ##1 s_erase_done)
    else $error("locks not cleared at erase end");
  a_fuse_sw_ro: assert property ((apb_acc && pwrite && paddr == `FSP_ADDR_FUSE && !prog_fuse_wr)
    |=> s_q.fuse == $past(s_q.fuse) && pslverr)
    else $error("software changed fuse");
  a_sig_ro: assert property ((apb_acc && pwrite && paddr == `FSP_ADDR_DEVID) |=> pslverr)
    else $error("signature write not refused");
  a_ee_map: assert property ((s_q.ee_map && daddr == `FSP_EE_MAP_BASE) |=>
    dspace == fsp_pkg::FSP_DS_EEPROM)
    else $error("mapped eeprom not decoded");
  a_bit_io: assert property ((daddr == 16'h0020) |=> dinfo[1] == 1'b0 && dinfo[2])
    else $error("bit io range wrong");
  a_words_follow: assert property (req.valid |=> fl_words == $past(fl_instr_long))
    else $error("instruction length not passed on");
  a_idle_no_write: assert property (!req.valid |=> !fl_grant && !fl_mem_we)
    else $error("grant without a request");
  a_tbl_write_lock: assert property ((req.valid && fl_write && fl_waddr >= `FSP_TBL_FIRST &&
    fl_waddr <= `FSP_TBL_LAST && !s_q.locks.tbl[0]) |=> !fl_mem_we)
    else $error("locked table write performed");
  a_beyond_boot: assert property ((fl_valid && fl_waddr > `FSP_BOOT_LAST) |=> !fl_grant)
    else $error("address beyond boot granted");
  a_short_io: assert property ((daddr == 16'h003F) |=> dinfo[2] && !dinfo[1])
    else $error("short io range wrong");
  a_gpr_edge: assert property ((daddr == 16'h0010) |=> !dinfo[0] && dinfo[1])
    else $error("general storage range wrong");
  a_fuse_prog: assert property (prog_fuse_wr && !s_q.erasing |=> s_q.fuse == $past(prog_fuse_data))
    else $error("programmer fuse write lost");
  a_serial_ro: assert property ((apb_acc && pwrite && paddr == `FSP_ADDR_SERIAL) |=> pslverr)
    else $error("serial write not refused");
  a_prog_write_ok: assert property ((req.valid && fl_from_prog && fl_write && !fl_spm &&
    fl_waddr <= `FSP_APP_LAST && s_q.locks.app[0]) |=> fl_mem_we)
    else $error("programmer write refused");
endmodule : fsp_flash_section_protection_map

// ---- fsp_pkg.sv ----
// types shared by the flash protection map
package fsp_pkg;
  typedef enum logic [1:0] {FSP_REG_APP, FSP_REG_TBL, FSP_REG_BOOT, FSP_REG_NONE} fsp_region_t;
  typedef enum logic [1:0] {FSP_DS_IO, FSP_DS_EEPROM, FSP_DS_SRAM} fsp_dspace_t;
  typedef struct packed {
    logic [1:0] app;
    logic [1:0] tbl;
    logic [1:0] boot;
  } fsp_locks_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic from_prog;
    logic store_program_word_instr;
    logic [17:0] waddr;
    logic [17:0] fetch_pc;
  } fsp_freq_t;
  typedef struct packed {
    logic is_io;
    logic is_ee_mapped;
    logic short_io_ok;
    logic bit_io_ok;
    logic is_gpr;
  } fsp_dinfo_t;
endpackage : fsp_pkg

// ---- fsp_prog_model.sv ----
// external programmer model driving the program and debug port commands
`timescale 1ns/1ps
module fsp_prog_model
(
  input wire logic pclk,
  output logic prog_fuse_wr,
  output logic [7:0] prog_fuse_data,
  output logic prog_lock_wr,
  output logic [5:0] prog_lock_data,
  output logic prog_chip_erase,
  output logic prog_user_erase,
  output logic prog_user_wr,
  output logic [7:0] prog_user_idx,
  output logic [15:0] prog_user_data
);
  // ****************
  // command pulses
  // ****************
  initial
  begin
    {prog_fuse_wr, prog_lock_wr, prog_chip_erase, prog_user_erase, prog_user_wr} = 5'h00;
    prog_fuse_data = 8'h00;
    prog_lock_data = 6'h00;
    prog_user_idx = 8'h00;
    prog_user_data = 16'h0000;
  end

  // one-cycle command, k = {fuse, lock, chip erase, user erase, user write}
  task cmd(input logic [4:0] k, input logic [15:0] d, input logic [7:0] idx);
    @(posedge pclk);
    {prog_fuse_wr, prog_lock_wr, prog_chip_erase, prog_user_erase, prog_user_wr} <= k;
    prog_fuse_data <= d[7:0];
    prog_lock_data <= d[5:0];
    prog_user_data <= d;
    prog_user_idx <= idx;
    @(posedge pclk);
    {prog_fuse_wr, prog_lock_wr, prog_chip_erase, prog_user_erase, prog_user_wr} <= 5'h00;
    // inverted after use so a stale value is never mistaken for held data
    prog_fuse_data <= ~d[7:0];
    prog_lock_data <= ~d[5:0];
    prog_user_data <= ~d;
    prog_user_idx <= ~idx;
  endtask : cmd
endmodule : fsp_prog_model

// ---- testbench.sv ----
// self-checking bench for the flash protection map
`timescale 1ns/1ps
module testbench;
  // ****************
  // signals
  // ****************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic fl_valid = 1'b0;
  logic fl_write = 1'b0;
  logic fl_from_prog = 1'b0;
  logic fl_spm = 1'b0;
  logic [17:0] fl_waddr = 18'h00000;
  logic [17:0] fl_fetch_pc = 18'h00000;
  logic [15:0] fl_wdata = 16'h0000;
  logic fl_instr_long = 1'b0;
  logic prog_fuse_wr, prog_lock_wr, prog_chip_erase, prog_user_erase, prog_user_wr;
  logic [7:0] prog_fuse_data, prog_user_idx;
  logic [5:0] prog_lock_data;
  logic [15:0] prog_user_data, fl_mem_wdata, wd;
  logic [15:0] daddr = 16'h0000;
  logic fl_grant, fl_mem_we, fl_words, fl_mem_erase, erase_busy, e, g, we;
  logic [7:0] cal_out;
  logic [1:0] dspace;
  logic [4:0] dinfo;
  logic [31:0] r;
  int errors = 0;
  int checks_done = 0;
  localparam logic [23:0] DEV_ID = 24'h5A3C71; // arbitrary value
  localparam logic [7:0] CAL_AUTO = 8'h3C;

  always #12.5 pclk = ~pclk;

  fsp_flash_section_protection_map #(.DEV_ID(DEV_ID), .SERIAL(32'h13579BDF),
    .CAL_AUTO(CAL_AUTO), .USER_ROW_WORDS(256)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .fl_valid, .fl_write, .fl_from_prog, .fl_spm,
    .fl_waddr, .fl_fetch_pc, .fl_wdata, .fl_instr_long, .prog_fuse_wr, .prog_fuse_data,
    .prog_lock_wr, .prog_lock_data, .prog_chip_erase, .prog_user_erase, .prog_user_wr,
    .prog_user_idx, .prog_user_data, .daddr, .fl_grant, .fl_mem_we, .fl_mem_wdata, .fl_words,
    .fl_mem_erase, .erase_busy, .cal_out, .dspace, .dinfo);
  fsp_prog_model prog (.pclk, .prog_fuse_wr, .prog_fuse_data, .prog_lock_wr, .prog_lock_data,
    .prog_chip_erase, .prog_user_erase, .prog_user_wr, .prog_user_idx, .prog_user_data);

  // ****************
  // shared tasks
  // ****************
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb answer", {31'h0, pready}, 32'h1);
  endtask : apb

  task fl(input logic w, input logic pr, input logic store_program_word_instr, input logic [17:0] a,
    input logic [17:0] pc, output logic gr, output logic wr, output logic [15:0] wv);
    @(posedge pclk);
    fl_valid <= 1'b1;
    fl_write <= w;
    fl_from_prog <= pr;
    fl_spm <= store_program_word_instr;
    fl_waddr <= a;
    fl_fetch_pc <= pc;
    fl_wdata <= a[15:0] ^ 16'hA5C3;
    fl_instr_long <= store_program_word_instr;
    @(posedge pclk);
    fl_valid <= 1'b0;
    @(posedge pclk);
    gr = fl_grant;
    wr = fl_mem_we;
    wv = fl_mem_wdata;
  endtask : fl

  // ****************
  // scenarios
  // ****************
  task t_reset;
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk("lock reset", r, 32'h0000003F);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk("fuse reset", r, 32'h000000FF);
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk("device id", r, {8'h00, DEV_ID});
    chk("auto cal", {24'h0, cal_out}, {24'h0, CAL_AUTO});
  endtask : t_reset

  task t_regs;
    apb(1'b1, 12'h004, 32'h0, r, e);
    chk("fuse sw write", {31'h0, e}, 32'h1);
    apb(1'b1, 12'h010, 32'h0, r, e);
    chk("id write", {31'h0, e}, 32'h1);
    apb(1'b1, 12'h014, 32'h0, r, e);
    chk("serial write", {31'h0, e}, 32'h1);
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk("id kept", r, {8'h00, DEV_ID});
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk("unmapped", {31'h0, e}, 32'h1);
    prog.cmd(5'h10, 16'h00A5, 8'h00);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk("fuse by programmer", r, 32'h000000A5);
    apb(1'b1, 12'h044, 32'h0000005A, r, e);
    apb(1'b0, 12'h044, 32'h0, r, e);
    chk("gpr store", r & 32'h000000FF, 32'h0000005A);
  endtask : t_regs

  task t_flash;
    apb(1'b1, 12'h000, 32'h0000001F, r, e);
    apb(1'b1, 12'h000, 32'h0000003F, r, e);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk("lock tightens only", r, 32'h0000001F);
    fl(1'b0, 1'b0, 1'b0, 18'h1EFFF, 18'h00010, g, we, wd);
    chk("app read blocked", {31'h0, g}, 32'h0);
    fl(1'b0, 1'b0, 1'b0, 18'h1F000, 18'h00010, g, we, wd);
    chk("table read", {31'h0, g}, 32'h1);
    fl(1'b0, 1'b0, 1'b0, 18'h21000, 18'h00010, g, we, wd);
    chk("beyond boot", {31'h0, g}, 32'h0);
    fl(1'b1, 1'b1, 1'b0, 18'h1EFFF, 18'h00010, g, we, wd);
    chk("programmer write", {31'h0, we}, 32'h1);
    chk("write word", {16'h0, wd}, 32'h00004A3C);
    fl(1'b1, 1'b0, 1'b1, 18'h1F000, 18'h00100, g, we, wd);
    chk("store from app", {30'h0, g, we}, 32'h0);
    fl(1'b1, 1'b0, 1'b1, 18'h20000, 18'h20010, g, we, wd);
    chk("store from boot", {31'h0, we}, 32'h1);
    chk("two-word flag", {31'h0, fl_words}, 32'h1);
    prog.cmd(5'h08, 16'h001E, 8'h00);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk("programmer lock", r, 32'h0000001E);
    fl(1'b1, 1'b0, 1'b1, 18'h20000, 18'h20010, g, we, wd);
    chk("boot write locked", {31'h0, we}, 32'h0);
    fl(1'b0, 1'b0, 1'b0, 18'h20000, 18'h20010, g, we, wd);
    chk("boot read", {31'h0, g}, 32'h1);
    chk("one-word flag", {31'h0, fl_words}, 32'h0);
    apb(1'b1, 12'h000, 32'h0000001A, r, e);
    fl(1'b1, 1'b1, 1'b0, 18'h1F000, 18'h00010, g, we, wd);
    chk("table write locked", {31'h0, we}, 32'h0);
  endtask : t_flash

  task t_erase;
    int n;
    n = 0;
    prog.cmd(5'h01, 16'hBEEF, 8'h03);
    apb(1'b0, 12'h80C, 32'h0, r, e);
    chk("user row", r, 32'h0000BEEF);
    prog.cmd(5'h04, 16'h0000, 8'h00);
    fork
      apb(1'b0, 12'h000, 32'h0, r, e);
      fl(1'b0, 1'b1, 1'b0, 18'h1F000, 18'h00010, g, we, wd);
      repeat (14)
      begin
        @(posedge pclk);
        n = n + int'(erase_busy === 1'b1 && fl_mem_erase === 1'b1);
      end
    join
    chk("locks kept mid erase", r, 32'h0000001A);
    chk("access during erase", {31'h0, g}, 32'h0);
    chk("erase length", n, 32'h8);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk("locks cleared", r, 32'h0000003F);
    apb(1'b0, 12'h80C, 32'h0, r, e);
    chk("user row kept", r, 32'h0000BEEF);
    prog.cmd(5'h02, 16'h0000, 8'h00);
    apb(1'b0, 12'h80C, 32'h0, r, e);
    chk("user erase", r, 32'h0000FFFF);
  endtask : t_erase

  task t_decode;
    logic [15:0] a [6] = '{16'h000F, 16'h0010, 16'h001F, 16'h0020, 16'h003F, 16'h0040};
    logic [2:0] x [6] = '{3'h7, 3'h6, 3'h6, 3'h4, 3'h4, 3'h0};
    for (int i = 0; i < 6; i++)
    begin
      @(posedge pclk);
      daddr <= a[i];
      repeat (2) @(posedge pclk);
      chk("io reach", {29'h0, dinfo[2:0]}, {29'h0, x[i]});
    end
    apb(1'b1, 12'h008, 32'h00000001, r, e);
    daddr <= 16'h1000;
    repeat (2) @(posedge pclk);
    chk("eeprom mapped", {29'h0, dspace, dinfo[3]}, 32'h3);
    apb(1'b1, 12'h008, 32'h00000000, r, e);
    repeat (2) @(posedge pclk);
    chk("eeprom unmapped", {31'h0, dinfo[3]}, 32'h0);
  endtask : t_decode

  // ****************
  // run control
  // ****************
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_flash;
    t_erase;
    t_decode;
    give_verdict;
  end

  // whole run is a few hundred cycles, so this limit only trips on a hang
  initial
  begin
    #(25 * 5000);
    errors++;
    give_verdict;
  end
endmodule : testbench
